// >>> src/periph_irq_enables.sv
// Purpose: per-source peripheral interrupt enables gating requests toward the core
// Assumes: request flags come from logic on aclk, held as levels by each peripheral
// Notes:   registers reached over AXI4-Lite; status/clear/enable gather forwarded events
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`include "irq_enable_map.svh"
`default_nettype none

module periph_irq_enables #(
  parameter bit HAS_PARALLEL_PORT = 1'b1
) (
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic [7:0]  awaddr,
  input  wire  logic [2:0]  awprot,
  input  wire  logic        awvalid,
  output logic              awready,
  input  wire  logic [31:0] wdata,
  input  wire  logic [3:0]  wstrb,
  input  wire  logic        wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire  logic        bready,
  input  wire  logic [7:0]  araddr,
  input  wire  logic [2:0]  arprot,
  input  wire  logic        arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire  logic        rready,
  input  wire  logic [7:0]  irq_flag_a,
  input  wire  logic [7:0]  irq_flag_b,
  output logic [15:0]       fwd_req,
  output logic              periph_irq,
  output logic              irq
);

  logic [7:0]              peripheral_irq_enable_a_ff;
  logic [7:0]              peripheral_irq_enable_b_ff;
  irq_enable_pkg::ctrl_s   ctrl_ff;
  logic [15:0]             fwd_ff;
  logic                    periph_irq_ff;
  logic [15:0]             status_ff;
  logic [15:0]             ien_ff;
  logic                    irq_ff;
  logic [15:0]             nxt_fwd;
  logic                    nxt_periph_irq;
  logic [15:0]             evt_set;
  logic [15:0]             evt_clr;
  logic [7:0]              en_a_mask;
  irq_enable_pkg::wr_req_s wr_req;
  logic                    wr_fire;
  logic                    wr_err;
  logic                    rd_fire;
  logic [31:0]             rd_data;
  logic                    rd_err;

  // bit 7 of enable A absent on the small package
  assign en_a_mask = HAS_PARALLEL_PORT ? 8'hFF : 8'h7F;

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `IRQEN_OFF_EN_A, `IRQEN_OFF_EN_B, `IRQEN_OFF_CTRL, `IRQEN_OFF_FLAGS,
      `IRQEN_OFF_STATUS, `IRQEN_OFF_CLEAR, `IRQEN_OFF_IEN: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
    lane_merge = {s[1] ? d[15:8] : old_v[15:8], s[0] ? d[7:0] : old_v[7:0]};
  endfunction

  function automatic logic wr_hit(input irq_enable_pkg::wr_req_s r,
                                  input logic [7:0] off);
    wr_hit = (r.addr == off);
  endfunction

  axil_port u_axil_port (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_req  (wr_req),
    .wr_fire (wr_fire),
    .wr_err  (wr_err),
    .rd_fire (rd_fire),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  assign wr_err = !is_mapped(wr_req.addr);
  assign rd_err = !is_mapped(araddr);

  // enable registers, written only through byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peripheral_irq_enable_a_ff <= `IRQEN_RST_EN_A;
      peripheral_irq_enable_b_ff <= `IRQEN_RST_EN_B;
    end else if (wr_fire && wr_req.strb[0]) begin
      if (wr_hit(wr_req, `IRQEN_OFF_EN_A)) begin
        peripheral_irq_enable_a_ff <= wr_req.data[7:0] & en_a_mask;
      end
      if (wr_hit(wr_req, `IRQEN_OFF_EN_B)) begin
        peripheral_irq_enable_b_ff <= wr_req.data[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `IRQEN_RST_CTRL;
    end else if (wr_fire && wr_req.strb[0] && wr_hit(wr_req, `IRQEN_OFF_CTRL)) begin
      ctrl_ff.group_en  <= wr_req.data[`IRQEN_CTRL_GROUP];
      ctrl_ff.prio_mode <= wr_req.data[`IRQEN_CTRL_PRIO];
    end
  end

  // per-source gating: bits 7..0 from enable A, 15..8 from enable B
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_gate
      assign nxt_fwd[g]     = irq_flag_a[g] & peripheral_irq_enable_a_ff[g] & en_a_mask[g];
      assign nxt_fwd[g + 8] = irq_flag_b[g] & peripheral_irq_enable_b_ff[g];
    end
  endgenerate

  // without priority mode the group enable is the final gate
  assign nxt_periph_irq = (|nxt_fwd) & (ctrl_ff.prio_mode | ctrl_ff.group_en);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fwd_ff        <= 16'h0000;
      periph_irq_ff <= 1'b0;
    end else begin
      fwd_ff        <= nxt_fwd;
      periph_irq_ff <= nxt_periph_irq;
    end
  end

  // sticky events on each newly forwarded request; set wins over clear
  assign evt_set = nxt_fwd & ~fwd_ff;
  assign evt_clr = (wr_fire && wr_hit(wr_req, `IRQEN_OFF_CLEAR))
                 ? lane_merge(16'h0000, wr_req.data, wr_req.strb) : 16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= `IRQEN_RST_STATUS;
    end else begin
      status_ff <= (status_ff & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ien_ff <= `IRQEN_RST_IEN;
    end else if (wr_fire && wr_hit(wr_req, `IRQEN_OFF_IEN)) begin
      ien_ff <= lane_merge(ien_ff, wr_req.data, wr_req.strb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(((status_ff & ~evt_clr) | evt_set) & ien_ff);
    end
  end

  // read mux; the clear register reads as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (araddr)
      `IRQEN_OFF_EN_A:   rd_data[7:0]  = peripheral_irq_enable_a_ff & en_a_mask;
      `IRQEN_OFF_EN_B:   rd_data[7:0]  = peripheral_irq_enable_b_ff;
      `IRQEN_OFF_CTRL:   rd_data[1:0]  = {ctrl_ff.prio_mode, ctrl_ff.group_en};
      `IRQEN_OFF_FLAGS:  rd_data[15:0] = {irq_flag_b, irq_flag_a & en_a_mask};
      `IRQEN_OFF_STATUS: rd_data[15:0] = status_ff;
      `IRQEN_OFF_IEN:    rd_data[15:0] = ien_ff;
      default:           rd_data = 32'h0000_0000;
    endcase
  end

  assign fwd_req    = fwd_ff;
  assign periph_irq = periph_irq_ff;
  assign irq        = irq_ff;

  // ---- checks ----
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_group_gate_off: assert property (
    (!ctrl_ff.prio_mode && !ctrl_ff.group_en) |=> !periph_irq_ff)
    else $error("peripheral interrupt passed without group enable");
  a_group_gate_on: assert property (
    (ctrl_ff.group_en && (|nxt_fwd)) |=> periph_irq_ff && (fwd_ff != 16'h0000))
    else $error("enabled request not passed with group enable");
  a_parallel_bit: assert property (
    (irq_flag_a[7] && peripheral_irq_enable_a_ff[7]) |=> fwd_ff[7])
    else $error("parallel port request not forwarded");
  a_conversion_bit: assert property (
    (irq_flag_a[6] && !peripheral_irq_enable_a_ff[6]) |=> !fwd_ff[6])
    else $error("disabled conversion request forwarded");
  a_rx_bit: assert property (
    (irq_flag_a[5] && peripheral_irq_enable_a_ff[5]) |=> fwd_ff[5])
    else $error("serial receive request not forwarded");
  a_tx_bit: assert property (
    (irq_flag_a[4] && !peripheral_irq_enable_a_ff[4]) |=> !fwd_ff[4])
    else $error("disabled serial transmit request forwarded");
  a_sync_bit: assert property (
    (irq_flag_a[3] && peripheral_irq_enable_a_ff[3]) |=> fwd_ff[3])
    else $error("sync serial request not forwarded");
  a_capture_bit: assert property (
    (irq_flag_a[2] && peripheral_irq_enable_a_ff[2]) |=> fwd_ff[2])
    else $error("capture one request not forwarded");
  a_match_bit: assert property (
    (irq_flag_a[1] && peripheral_irq_enable_a_ff[1]) |=> fwd_ff[1])
    else $error("timer two match request not forwarded");
  a_overflow_bit: assert property (
    (irq_flag_a[0] && peripheral_irq_enable_a_ff[0]) |=> fwd_ff[0])
    else $error("timer one overflow request not forwarded");
  a_second_reg: assert property (
    (fwd_ff[15:8] != 8'h00) |-> (($past(irq_flag_b) & $past(peripheral_irq_enable_b_ff)) != 8'h00))
    else $error("enable B forwarded without flag and enable");
  a_enable_write: assert property (
    (wr_fire && wr_req.strb[0] && wr_req.addr == `IRQEN_OFF_EN_B)
      |=> peripheral_irq_enable_b_ff == $past(wr_req.data[7:0]))
    else $error("enable B write not stored");
  a_parallel_absent: assert property (
    !HAS_PARALLEL_PORT |-> !peripheral_irq_enable_a_ff[7] && !fwd_ff[7])
    else $error("absent parallel port bit set");
  a_flag_and_enable: assert property (
    fwd_ff == {$past(irq_flag_b) & $past(peripheral_irq_enable_b_ff),
               $past(irq_flag_a) & $past(peripheral_irq_enable_a_ff) & en_a_mask})
    else $error("forwarded request differs from flag and enable");

  c_fwd_group: cover property (ctrl_ff.group_en ##1 periph_irq_ff);
  c_prio_mode: cover property (ctrl_ff.prio_mode && !ctrl_ff.group_en ##1 periph_irq_ff);
  c_status_irq: cover property (evt_set != 16'h0000 ##1 irq_ff);
  c_clear_race: cover property (wr_fire && (evt_set & evt_clr) != 16'h0000);

endmodule // periph_irq_enables
`default_nettype wire

// >>> src/irq_enable_map.svh
// Purpose: register offsets, field positions and reset values of the enable block
// Assumes: byte addresses on a 32-bit register bus, one word per register
// Notes:   definitions only
`ifndef IRQ_ENABLE_MAP_SVH
`define IRQ_ENABLE_MAP_SVH

`define IRQEN_ADDR_W        8
`define IRQEN_OFF_EN_A      8'h00
`define IRQEN_OFF_EN_B      8'h04
`define IRQEN_OFF_CTRL      8'h08
`define IRQEN_OFF_FLAGS     8'h0C
`define IRQEN_OFF_STATUS    8'h10
`define IRQEN_OFF_CLEAR     8'h14
`define IRQEN_OFF_IEN       8'h18

`define IRQEN_RST_EN_A      8'h00
`define IRQEN_RST_EN_B      8'h00
`define IRQEN_RST_CTRL      2'h0
`define IRQEN_RST_STATUS    16'h0000
`define IRQEN_RST_IEN       16'h0000

`define IRQEN_CTRL_GROUP    0
`define IRQEN_CTRL_PRIO     1
`define IRQEN_PARALLEL_BIT  7

`endif

// >>> src/irq_enable_pkg.sv
// Purpose: shared types of the peripheral interrupt enable block
// Assumes: nothing beyond the map header
// Notes:   register bus side uses wr_req_s between the two modules; ctrl_s stays in the enable block
`default_nettype none
package irq_enable_pkg;

  typedef struct packed {
    logic       prio_mode;
    logic       group_en;
  } ctrl_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wr_req_s;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_e;

endpackage
`default_nettype wire

// >>> src/axil_port.sv
// Purpose: AXI4-Lite slave handshake, one write and one read in flight
// Assumes: decode and storage live in the parent
// Notes:   write fires once address and data are both held
`default_nettype none
module axil_port (
  input  wire  logic                       aclk,
  input  wire  logic                       aresetn,
  input  wire  logic [7:0]                 awaddr,
  input  wire  logic                       awvalid,
  output logic                             awready,
  input  wire  logic [31:0]                wdata,
  input  wire  logic [3:0]                 wstrb,
  input  wire  logic                       wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire  logic                       bready,
  input  wire  logic [7:0]                 araddr,
  input  wire  logic                       arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire  logic                       rready,
  output irq_enable_pkg::wr_req_s          wr_req,
  output logic                             wr_fire,
  input  wire  logic                       wr_err,
  output logic                             rd_fire,
  input  wire  logic [31:0]                rd_data,
  input  wire  logic                       rd_err
);

  logic                    aw_held_ff;
  logic                    w_held_ff;
  logic                    awready_ff;
  logic                    wready_ff;
  logic                    bvalid_ff;
  logic                    arready_ff;
  logic                    rvalid_ff;
  logic [1:0]              bresp_ff;
  logic [1:0]              rresp_ff;
  logic [31:0]             rdata_ff;
  irq_enable_pkg::wr_req_s req_ff;

  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_req  = req_ff;
  assign rd_fire = arvalid && arready_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'b00;
      req_ff     <= '0;
    end else begin
      if (awvalid && awready_ff) begin
        req_ff.addr <= awaddr;
        aw_held_ff  <= 1'b1;
        awready_ff  <= 1'b0;
      end
      if (wvalid && wready_ff) begin
        req_ff.data <= wdata;
        req_ff.strb <= wstrb;
        w_held_ff   <= 1'b1;
        wready_ff   <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_err ? irq_enable_pkg::RESP_SLVERR : irq_enable_pkg::RESP_OKAY;
      end
      if (bvalid_ff && bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= 2'b00;
    end else if (rd_fire) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= rd_data;
      rresp_ff   <= rd_err ? irq_enable_pkg::RESP_SLVERR : irq_enable_pkg::RESP_OKAY;
    end else if (rvalid_ff && rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign awready = awready_ff;
  assign wready  = wready_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = arready_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

endmodule // axil_port
`default_nettype wire

// >>> test/periph_flag_model.sv
// Purpose: peripheral side model holding request flags as levels
// Assumes: one clock, flags change just after the rising edge
// Notes:   bench commands which flags the peripherals raise
`default_nettype none
module periph_flag_model (
  input  wire logic        aclk,
  input  wire logic [15:0] raise,
  output logic      [7:0]  irq_flag_a,
  output logic      [7:0]  irq_flag_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // a peripheral holds its flag until the bench drops its raise bit
  always @(posedge aclk) begin
    irq_flag_a <= raise[7:0];
    irq_flag_b <= raise[15:8];
  end
endmodule // periph_flag_model
`default_nettype wire

// >>> test/peripheral_interrupt_enables_bench.sv
// Purpose: self-checking bench of the peripheral interrupt enable block
// Assumes: AXI4-Lite master tasks, flag model on the peripheral side
// Notes:   one task per scenario, verdict in finish_test
`include "irq_enable_map.svh"
`default_nettype none
module peripheral_interrupt_enables_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] rdata_small;
  logic [31:0] rd_small = 32'h0;
  logic [15:0] fwd_req_small;
  logic [7:0]  irq_flag_a, irq_flag_b;
  logic [15:0] raise = 16'h0000;
  logic [15:0] fwd_req;
  logic        periph_irq, irq;
  int          n_fail = 0;
  int          num_checks = 0;

  periph_irq_enables u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq_flag_a(irq_flag_a), .irq_flag_b(irq_flag_b),
    .fwd_req(fwd_req), .periph_irq(periph_irq), .irq(irq)
  );
  // small package variant on the same bus, watched for the absent parallel port bit
  periph_irq_enables #(.HAS_PARALLEL_PORT(1'b0)) u_dut_small (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(),
    .bresp(), .bvalid(), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(), .rdata(rdata_small), .rresp(), .rvalid(),
    .rready(rready), .irq_flag_a(irq_flag_a), .irq_flag_b(irq_flag_b),
    .fwd_req(fwd_req_small), .periph_irq(), .irq()
  );
  periph_flag_model u_flags (
    .aclk(aclk), .raise(raise), .irq_flag_a(irq_flag_a), .irq_flag_b(irq_flag_b)
  );

  initial begin
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    // start one edge after the previous transfer released its signals
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      // handshakes judged on values standing before the edge
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end while (!hb);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      rd_small = rdata_small;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end while (!hr);
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", 32'(2'b00), 32'(r));
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(n, e, d);
  endtask

  task automatic settle;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic t_regs;
    rd_chk("enable_a reset", `IRQEN_OFF_EN_A, 32'h0);
    rd_chk("enable_b reset", `IRQEN_OFF_EN_B, 32'h0);
    wr_ok(`IRQEN_OFF_EN_A, 32'h0000_00A5);
    wr_ok(`IRQEN_OFF_EN_B, 32'h0000_005A);
    rd_chk("enable_a rw", `IRQEN_OFF_EN_A, 32'h0000_00A5);
    chk("small enable_a", 32'h0000_0025, rd_small);
    rd_chk("enable_b rw", `IRQEN_OFF_EN_B, 32'h0000_005A);
    $display("test regs done");
  endtask

  task automatic t_per_bit;
    logic [15:0] e;
    wr_ok(`IRQEN_OFF_CTRL, 32'h1);
    @(posedge aclk);
    raise <= 16'hFFFF;
    for (int i = 0; i < 16; i++) begin
      e = 16'h0001 << i;
      wr_ok(`IRQEN_OFF_EN_A, {24'h0, e[7:0]});
      wr_ok(`IRQEN_OFF_EN_B, {24'h0, e[15:8]});
      settle();
      chk("fwd_req", {16'h0, e}, {16'h0, fwd_req});
      chk("periph_irq", 32'h1, {31'h0, periph_irq});
      chk("small fwd_req", {16'h0, e & 16'hFF7F}, {16'h0, fwd_req_small});
      @(posedge aclk);
    end
    wr_ok(`IRQEN_OFF_EN_B, 32'h0);
    settle();
    chk("fwd after disable", 32'h0, {16'h0, fwd_req});
    rd_chk("flags kept", `IRQEN_OFF_FLAGS, 32'h0000_FFFF);
    chk("small flags", 32'h0000_FF7F, rd_small);
    $display("test per_bit done");
  endtask

  task automatic t_group;
    wr_ok(`IRQEN_OFF_EN_A, 32'hFF);
    wr_ok(`IRQEN_OFF_EN_B, 32'hFF);
    wr_ok(`IRQEN_OFF_CTRL, 32'h0);
    settle();
    chk("fwd no group", 32'hFFFF, {16'h0, fwd_req});
    chk("irq no group", 32'h0, {31'h0, periph_irq});
    @(posedge aclk);
    wr_ok(`IRQEN_OFF_CTRL, 32'h2);
    settle();
    chk("irq prio mode", 32'h1, {31'h0, periph_irq});
    $display("test group done");
  endtask

  task automatic t_status;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge aclk);
    raise <= 16'h0000;
    wr_ok(`IRQEN_OFF_CTRL, 32'h1);
    wr_ok(`IRQEN_OFF_CLEAR, 32'hFFFF);
    wr_ok(`IRQEN_OFF_IEN, 32'h0);
    rd_chk("status clear", `IRQEN_OFF_STATUS, 32'h0);
    raise <= 16'h0101;
    settle();
    rd_chk("status set", `IRQEN_OFF_STATUS, 32'h0101);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr_ok(`IRQEN_OFF_IEN, 32'h0100);
    settle();
    chk("irq enabled", 32'h1, {31'h0, irq});
    wr_ok(`IRQEN_OFF_CLEAR, 32'h0100);
    settle();
    rd_chk("status after w1c", `IRQEN_OFF_STATUS, 32'h0001);
    chk("irq after clear", 32'h0, {31'h0, irq});
    rd(8'h1C, d, r);
    chk("unmapped rresp", 32'(2'b10), 32'(r));
    chk("unmapped rdata", 32'h0, d);
    wr(8'h1C, 32'hFFFF_FFFF, r);
    chk("unmapped bresp", 32'(2'b10), 32'(r));
    $display("test status done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #40000;
    n_fail++;
    $display("FAIL watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_per_bit();
    t_group();
    t_status();
    finish_test();
  end
endmodule // peripheral_interrupt_enables_bench
`default_nettype wire
